// ==== fbdc_consts.vh ====
`ifndef FBDC_CONSTS_VH
`define FBDC_CONSTS_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define FBDC_ADDR_ERROR_CODE     16'h1020
`define FBDC_ADDR_ERROR_ARGUMENT 16'h1021
`define FBDC_ADDR_WORD_OUT_BITS  16'h1022
`define FBDC_ADDR_WORD_IN_BITS   16'h1023
`define FBDC_ADDR_BIT_OUT_COUNT  16'h1024
`define FBDC_ADDR_BIT_IN_COUNT   16'h1025
`define FBDC_ADDR_BOOT_SOURCE    16'h1028
`define FBDC_ADDR_STATISTICS     16'h1029
`define FBDC_ADDR_CONNECTIONS    16'h102A
`define FBDC_ADDR_BUS_RESTART    16'h102B

// ----------------------------------------------------------------
// Boot source codes and reset value
// ----------------------------------------------------------------
`define FBDC_BOOT_NETWORK        16'h0001
`define FBDC_BOOT_DYNAMIC        16'h0002
`define FBDC_BOOT_STORED         16'h0004
`define FBDC_BOOT_RESET          16'h0004

// ----------------------------------------------------------------
// Statistics block layout
// ----------------------------------------------------------------
`define FBDC_STAT_WORDS          9
`define FBDC_STAT_LAST_INDEX     4'h8
`define FBDC_STAT_DEVICE_FAIL    0
`define FBDC_STAT_BAD_HEADER     1
`define FBDC_STAT_BAD_LENGTH     2
`define FBDC_STAT_BAD_FUNCTION   3
`define FBDC_STAT_BAD_ADDRESS    4
`define FBDC_STAT_BAD_VALUE      5
`define FBDC_STAT_OVER_REGS      6
`define FBDC_STAT_OVER_COILS     7
`define FBDC_STAT_RECEIVED       8
`define FBDC_ERR_EVENTS          6
`define FBDC_CLEAR_KEY_A         16'hAA55
`define FBDC_CLEAR_KEY_B         16'h55AA

// ----------------------------------------------------------------
// Request size limits
// ----------------------------------------------------------------
`define FBDC_MAX_REG_READ        16'h007D
`define FBDC_MAX_REG_WRITE       16'h0064
`define FBDC_MAX_COIL_READ       16'h07D0
`define FBDC_MAX_COIL_WRITE      16'h0320

// ----------------------------------------------------------------
// Common values
// ----------------------------------------------------------------
`define FBDC_WORD_ZERO           16'h0000
`define FBDC_WORD_ONE            16'h0001
`define FBDC_WORD_MAX            16'hFFFF

`endif

// ==== fbdc_stat_counter.v ====
`timescale 1ns/1ps
`include "fbdc_consts.vh"

module fbdc_stat_counter (
  input  wire        clk,
  input  wire        rstn,
  input  wire        ce,
  input  wire        clr,
  input  wire        inc,
  output reg  [15:0] count
);

  // ----------------------------------------------------------------
  // Saturating event counter, clear wins; an event in the clear cycle counts as 1
  // ----------------------------------------------------------------
  reg [15:0] next_count;

  always @* begin
    next_count = count;
    if (clr) begin
      next_count = inc ? `FBDC_WORD_ONE : `FBDC_WORD_ZERO;
    end else if (inc && (count != `FBDC_WORD_MAX)) begin
      next_count = count + `FBDC_WORD_ONE;
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      count <= `FBDC_WORD_ZERO;
    end else if (ce) begin
      count <= next_count;
    end
  end

endmodule // fbdc_stat_counter

// ==== fbdc_regs.v ====
`timescale 1ns/1ps
`include "fbdc_consts.vh"


module fbdc_regs (
  input  wire        clk,
  input  wire        rstn,
  input  wire        ce,
  input  wire        acc_req,
  input  wire        acc_write,
  input  wire [15:0] acc_addr,
  input  wire [3:0]  acc_index,
  input  wire [15:0] acc_wdata,
  output reg         acc_ack,
  output reg         acc_addr_err,
  output reg  [15:0] acc_rdata,
  input  wire [15:0] error_code,
  input  wire [15:0] error_argument,
  input  wire [15:0] word_output_image_bits,
  input  wire [15:0] word_input_image_bits,
  input  wire [15:0] bit_output_image_count,
  input  wire [15:0] bit_input_image_count,
  input  wire [15:0] open_connection_count,
  input  wire [5:0]  err_event,
  input  wire        mb_req_valid,
  input  wire [15:0] mb_reg_read_qty,
  input  wire [15:0] mb_reg_write_qty,
  input  wire [15:0] mb_coil_read_qty,
  input  wire [15:0] mb_coil_write_qty,
  output reg  [15:0] boot_source_select,
  output reg         module_bus_restart
);

  // ----------------------------------------------------------------
  // Statistics events
  // ----------------------------------------------------------------
  wire [8:0]   stat_inc;
  wire [143:0] stat_flat;
  wire         stat_clr;
  wire         wr_go;
  wire         rd_go;
  wire         over_regs;
  wire         over_coils;

  assign wr_go = acc_req && acc_write;
  assign rd_go = acc_req && !acc_write;

  assign over_regs  = (mb_reg_read_qty  > `FBDC_MAX_REG_READ) ||
                      (mb_reg_write_qty > `FBDC_MAX_REG_WRITE);
  assign over_coils = (mb_coil_read_qty  > `FBDC_MAX_COIL_READ) ||
                      (mb_coil_write_qty > `FBDC_MAX_COIL_WRITE);

  assign stat_inc[`FBDC_ERR_EVENTS-1:0] = err_event;
  assign stat_inc[`FBDC_STAT_OVER_REGS]  = mb_req_valid && over_regs;
  assign stat_inc[`FBDC_STAT_OVER_COILS] = mb_req_valid && over_coils;
  assign stat_inc[`FBDC_STAT_RECEIVED]   = mb_req_valid;

  assign stat_clr = wr_go && (acc_addr == `FBDC_ADDR_STATISTICS) &&
                    ((acc_wdata == `FBDC_CLEAR_KEY_A) ||
                     (acc_wdata == `FBDC_CLEAR_KEY_B));

  // ----------------------------------------------------------------
  // Counter bank
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `FBDC_STAT_WORDS; gi = gi + 1) begin : g_stat
      fbdc_stat_counter u_cnt (
        .clk   (clk),
        .rstn  (rstn),
        .ce    (ce),
        .clr   (stat_clr),
        .inc   (stat_inc[gi]),
        .count (stat_flat[gi*16 +: 16])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  reg [15:0] next_rdata;
  reg        next_err;

  always @* begin
    next_rdata = `FBDC_WORD_ZERO;
    next_err   = 1'b0;
    case (acc_addr)
      `FBDC_ADDR_ERROR_CODE:     next_rdata = error_code;
      `FBDC_ADDR_ERROR_ARGUMENT: next_rdata = error_argument;
      `FBDC_ADDR_WORD_OUT_BITS:  next_rdata = word_output_image_bits;
      `FBDC_ADDR_WORD_IN_BITS:   next_rdata = word_input_image_bits;
      `FBDC_ADDR_BIT_OUT_COUNT:  next_rdata = bit_output_image_count;
      `FBDC_ADDR_BIT_IN_COUNT:   next_rdata = bit_input_image_count;
      `FBDC_ADDR_BOOT_SOURCE:    next_rdata = boot_source_select;
      `FBDC_ADDR_CONNECTIONS:    next_rdata = open_connection_count;
      `FBDC_ADDR_STATISTICS: begin
        if (acc_index > `FBDC_STAT_LAST_INDEX) begin
          next_err = 1'b1;
        end else begin
          next_rdata = stat_flat[acc_index*16 +: 16];
        end
      end
      `FBDC_ADDR_BUS_RESTART:    next_err = 1'b1;
      default:                   next_err = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // Access answer, one word per access
  // ----------------------------------------------------------------
  reg wr_err;

  always @* begin
    case (acc_addr)
      `FBDC_ADDR_BOOT_SOURCE:  wr_err = 1'b0;
      `FBDC_ADDR_STATISTICS:   wr_err = 1'b0;
      `FBDC_ADDR_BUS_RESTART:  wr_err = 1'b0;
      default:                 wr_err = 1'b1;
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      acc_ack      <= 1'b0;
      acc_addr_err <= 1'b0;
      acc_rdata    <= `FBDC_WORD_ZERO;
    end else if (ce) begin
      acc_ack      <= acc_req;
      acc_addr_err <= rd_go ? next_err : (wr_go && wr_err);
      if (rd_go) begin
        acc_rdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Writable state
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      boot_source_select <= `FBDC_BOOT_RESET;
      module_bus_restart <= 1'b0;
    end else if (ce) begin
      module_bus_restart <= wr_go &&
                            (acc_addr == `FBDC_ADDR_BUS_RESTART);
      if (wr_go && (acc_addr == `FBDC_ADDR_BOOT_SOURCE)) begin
        boot_source_select <= acc_wdata;
      end
    end
  end

endmodule // fbdc_regs

// ==== fbdc_regs_asserts.sv ====
`timescale 1ns/1ps
module fbdc_regs_asserts (
  input logic        clk,
  input logic        rstn,
  input logic        ce,
  input logic        acc_req,
  input logic        acc_write,
  input logic [15:0] acc_addr,
  input logic [15:0] acc_wdata,
  input logic        acc_ack,
  input logic        acc_addr_err,
  input logic [15:0] acc_rdata,
  input logic [15:0] error_code,
  input logic [15:0] open_connection_count,
  input logic [15:0] boot_source_select,
  input logic        module_bus_restart
);
  wire rq = ce && acc_req;
  wire rd = rq && !acc_write;
  wire wr = rq && acc_write;
  wire wr_rst = wr && acc_addr == 16'h102B;
  wire wr_boot = wr && acc_addr == 16'h1028;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_ACK: assert property (rq |=> acc_ack)
    else $error("access not answered");
  AST_ERR_CODE: assert property (rd && acc_addr == 16'h1020 |=>
    acc_rdata == $past(error_code) && !acc_addr_err)
    else $error("error code read wrong");
  AST_CONN: assert property (rd && acc_addr == 16'h102A |=>
    acc_rdata == $past(open_connection_count))
    else $error("connection count read wrong");
  AST_RESTART: assert property (wr_rst |=> module_bus_restart)
    else $error("restart missing");
  AST_RESTART_CAUSE: assert property ($rose(module_bus_restart) |->
    $past(wr_rst))
    else $error("restart without write");
  AST_RD_RESTART: assert property (rd && acc_addr == 16'h102B |=>
    acc_addr_err && acc_rdata == 16'h0000)
    else $error("write-only place readable");
  AST_BOOT_WR: assert property (wr_boot |=>
    boot_source_select == $past(acc_wdata))
    else $error("boot source not stored");
  AST_BOOT_HOLD: assert property (!wr_boot |=>
    $stable(boot_source_select))
    else $error("boot source changed");
  cover property (wr_rst);
  cover property (rd && acc_addr == 16'h1029);
  cover property (wr && acc_wdata == 16'hAA55);
endmodule // fbdc_regs_asserts

bind fbdc_regs fbdc_regs_asserts i_chk (.clk(clk), .rstn(rstn), .ce(ce),
  .acc_req(acc_req), .acc_write(acc_write), .acc_addr(acc_addr),
  .acc_wdata(acc_wdata), .acc_ack(acc_ack), .acc_addr_err(acc_addr_err),
  .acc_rdata(acc_rdata), .error_code(error_code),
  .open_connection_count(open_connection_count),
  .boot_source_select(boot_source_select),
  .module_bus_restart(module_bus_restart));

// ==== fbdc_client_model.sv ====
`timescale 1ns/1ps
module fbdc_client_model (
  input  logic        clk,
  output logic        req,
  output logic        wr,
  output logic [15:0] addr,
  output logic [3:0]  idx,
  output logic [15:0] wd
);
  initial {req, wr, addr, idx, wd} = '0;
  // One word per access; afterwards req drops and addr and wd show the inverse
  task automatic acc(input logic w, input logic [15:0] a, d,
                     input logic [3:0] i);
    @(negedge clk);
    {req, wr, addr, idx, wd} = {1'h1, w, a, i, d};
    @(negedge clk);
    {req, addr, wd} = {1'h0, ~a, ~d};
  endtask
endmodule // fbdc_client_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic        clk, rstn, req, wr, ack, aerr, mbv, rst_p, ce;
  logic [15:0] addr, wd, rdat, boot;
  logic [3:0]  idx;
  logic [5:0]  ev;
  logic [63:0] qty;
  logic [15:0] cfg [7];
  int          mismatches, comparisons;
  fbdc_regs i_dut (.clk(clk), .rstn(rstn), .ce(ce), .acc_req(req),
    .acc_write(wr), .acc_addr(addr), .acc_index(idx), .acc_wdata(wd),
    .acc_ack(ack), .acc_addr_err(aerr), .acc_rdata(rdat),
    .error_code(cfg[0]), .error_argument(cfg[1]),
    .word_output_image_bits(cfg[2]), .word_input_image_bits(cfg[3]),
    .bit_output_image_count(cfg[4]), .bit_input_image_count(cfg[5]),
    .open_connection_count(cfg[6]), .err_event(ev), .mb_req_valid(mbv),
    .mb_reg_read_qty(qty[63:48]), .mb_reg_write_qty(qty[47:32]),
    .mb_coil_read_qty(qty[31:16]), .mb_coil_write_qty(qty[15:0]),
    .boot_source_select(boot), .module_bus_restart(rst_p));
  fbdc_client_model i_cli (.clk(clk), .req(req), .wr(wr), .addr(addr),
    .idx(idx), .wd(wd));
  task automatic chk(input logic [17:0] s, e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [3:0] i,
                    input logic [15:0] e, input logic er);
    i_cli.acc(1'h0, a, 16'h0000, i);
    chk({ack, aerr, rdat}, {1'h1, er, e});
  endtask
  task automatic wt(input logic [15:0] a, d, input logic er);
    i_cli.acc(1'h1, a, d, 4'h0);
    chk({ack, aerr}, {1'h1, er});
  endtask
  task automatic pulse(input logic [5:0] e, input logic v,
                       input logic [63:0] q);
    @(negedge clk);
    {ev, mbv, qty} = {e, v, q};
    @(negedge clk);
    {ev, mbv, qty} = {6'h00, 1'h0, ~q};
  endtask
  task automatic t_cfg;
    for (int i = 0; i < 7; i++)
      rd(i < 6 ? 16'h1020 + 16'(i) : 16'h102A, 4'h0, cfg[i], 1'h0);
  endtask
  task automatic t_boot;
    for (int i = 0; i < 3; i++) begin
      wt(16'h1028, 16'h0001 << i, 1'h0);
      rd(16'h1028, 4'h0, 16'h0001 << i, 1'h0);
      chk(boot, 16'h0001 << i);
    end
  endtask
  task automatic t_ce;
    @(negedge clk);
    ce = 1'h0;
    i_cli.acc(1'h1, 16'h1028, 16'h0002, 4'h0);
    chk({ack, boot}, {1'h0, 16'h0004});
    ce = 1'h1;
  endtask
  task automatic t_err;
    wt(16'h1020, 16'h5A5A, 1'h1);
    rd(16'h1020, 4'h0, cfg[0], 1'h0);
    rd(16'h102B, 4'h0, 16'h0000, 1'h1);
    rd(16'h1026, 4'h0, 16'h0000, 1'h1);
    rd(16'h1029, 4'h9, 16'h0000, 1'h1);
  endtask
  task automatic t_restart;
    wt(16'h102B, 16'h0000, 1'h0);
    chk(rst_p, 1'h1);
    @(negedge clk);
    chk(rst_p, 1'h0);
  endtask
  task automatic t_stats;
    logic [63:0] q [5] = '{64'h007E000000000000, 64'h0000006500000000,
      64'h0000000007D10000, 64'h0000000000000321, 64'h007D006407D00320};
    for (int i = 0; i < 6; i++) pulse(6'h01 << i, 1'h0, 64'h0);
    for (int i = 0; i < 5; i++) pulse(6'h00, 1'h1, q[i]);
    for (int k = 0; k < 9; k++)
      rd(16'h1029, 4'(k), k < 6 ? 16'h0001 : k < 8 ? 16'h0002 : 16'h0005, 1'h0);
    wt(16'h1029, 16'h1234, 1'h0);
    rd(16'h1029, 4'h0, 16'h0001, 1'h0);
    for (int j = 0; j < 2; j++) begin
      pulse(6'h3F, 1'h1, 64'h0);
      wt(16'h1029, j ? 16'h55AA : 16'hAA55, 1'h0);
      for (int k = 0; k < 9; k++) rd(16'h1029, 4'(k), 16'h0000, 1'h0);
    end
    @(negedge clk) ev = 6'h01;
    repeat (65540) @(negedge clk);
    ev = 6'h00;
    rd(16'h1029, 4'h0, 16'hFFFF, 1'h0);
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  initial begin
    {rstn, ev, mbv, qty} = '0;
    ce = 1'h1;
    for (int i = 0; i < 7; i++) cfg[i] = 16'h1111 * 16'(i + 1);
    repeat (4) @(negedge clk);
    rstn = 1'h1;
    chk(boot, 16'h0004);
    t_cfg;
    t_boot;
    t_ce;
    t_err;
    t_restart;
    t_stats;
    give_verdict;
  end
  initial begin
    #10000000;
    mismatches++;
    give_verdict;
  end
endmodule // tb_top
